// *** rtl/ocsc_onoff_cycle_skip_control.sv ***
// Functional notes
// RULE1: Hand back control when output-low holds past the qualify time.
// RULE2: Gate drive turns on only after a requested cycle's forward fall.
// RULE3: Gate drive is blocked while surge is flagged and until it clears.
// RULE4: Switch turns on at an enabled cycle start, off at limit or max duty.
// RULE5: A started switching cycle always completes regardless of feedback.
// RULE6: Free-running cycle clock; feedback is sampled at each cycle start.
// RULE7: Limit level follows the recent pattern of enabled cycles.
// RULE8: Four limit levels, stepped one at a time to stay out of audio.
// RULE9: Gate drive drops just before the next cycle request is sent.
// RULE10: Gate drive drops when the rectifier-off comparator trips.
// RULE11: Excess output current drops every other requested pulse.
// RULE12: In current regulation an output collapse leads to auto-restart.
// RULE13: Switching needs brown-in and is stopped by line overvoltage.
// RULE14: 14 unanswered requests or an unrequested cycle restart handshake.
// RULE15: Cycle clock averages 100 kHz with 6 kHz jitter at 1 kHz rate.
// RULE16: All comparator flags pass a two-flop synchroniser first.
`timescale 1ns/1ps
`default_nettype none
`include "ocsc_params.svh"
module ocsc_onoff_cycle_skip_control
  import ocsc_pkg::*;
#(
  parameter int ADDR_W = 4,
  parameter int QUAL_CYCLES = `OCSC_QUAL_CYC
) (
  input wire logic clk, // 100 MHz clock
  input wire logic resetn, // Async reset, active low
  input wire logic [ADDR_W-1:0] regAddr, // Register byte address
  input wire logic [31:0] regWrData, // Write data
  input wire logic regWrite, // Write strobe
  input wire logic regRead, // Read strobe
  output logic [31:0] regRdData, // Read data, cycle after strobe
  input wire logic feedbackLow, // Output below regulation point
  input wire logic outputLowCmp, // Output below restart level
  input wire logic currentSenseCmp, // Output current over threshold
  input wire logic surgeCmp, // Current sense over surge level
  input wire logic forwardSenseInput, // Winding forward voltage
  input wire logic rectOffCmp, // Rectifier voltage past turn-off
  input wire logic lineBrownIn, // Line above brown-in
  input wire logic lineOverVolt, // Line above overvoltage
  input wire logic currentLimitTrip, // Switch current at limit
  output logic cycleRequest, // One-cycle request to primary
  output logic rectifierGateDrive, // Synchronous rectifier gate
  output logic powerSwitchOn, // Primary switch drive
  output logic [1:0] currentLimitLevel, // Selected limit level
  output logic secondaryInControl // Secondary owns switching
);

  localparam int NSYNC = 9;
  localparam logic [10:0] PER_NOM = 11'(`OCSC_CYC_PERIOD);
  localparam logic [10:0] PER_MIN = 11'(`OCSC_CYC_PERIOD - `OCSC_JIT_OFS);
  localparam logic [10:0] PER_MAX = 11'(`OCSC_CYC_PERIOD + `OCSC_JIT_OFS);
  localparam logic [10:0] JIT_STEP = 11'(`OCSC_JIT_STEP);
  localparam logic [2:0] JIT_EVERY = 3'(`OCSC_JIT_EVERY);
  localparam logic [10:0] MAXDUTY = 11'(`OCSC_MAXDUTY_CYC);
  localparam logic [3:0] MISS_LIMIT = 4'(`OCSC_MISS_LIMIT);
  localparam logic [4:0] RESTART_CYC = 5'(`OCSC_RESTART_CYCLES);
  localparam int HL = `OCSC_HIST_LEN;
  // Count enabled cycles in the history window
  function automatic logic [3:0] onesCount(input logic [HL-1:0] v);
    logic [3:0] n;
    n = 4'h0;
    for (int i = 0; i < HL; i++) begin
      n = n + {3'h0, v[i]};
    end
    return n;
  endfunction
  logic [NSYNC-1:0] syncA_ff;
  logic [NSYNC-1:0] syncB_ff;
  logic fbLowS, outLowS, curSenseS, surgeS, fwdS, rectOffS;
  logic brownInS, overVoltS, limTripS;

  // Two-flop synchroniser for every comparator flag
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      syncA_ff <= '0;
      syncB_ff <= '0;
    end else begin
      syncA_ff <= {feedbackLow, outputLowCmp, currentSenseCmp, surgeCmp,
                   forwardSenseInput, rectOffCmp, lineBrownIn,
                   lineOverVolt, currentLimitTrip}; // RULE16
      syncB_ff <= syncA_ff; // RULE16
    end
  end
  assign {fbLowS, outLowS, curSenseS, surgeS, fwdS, rectOffS,
          brownInS, overVoltS, limTripS} = syncB_ff;
  // State registers
  logic [1:0] ctrl_ff, nxt_ctrl;
  logic [10:0] cycCnt_ff, nxt_cycCnt;
  logic [10:0] period_ff, nxt_period;
  logic jitUp_ff, nxt_jitUp;
  logic [2:0] jitDiv_ff, nxt_jitDiv;
  ocsc_ctl_t ctl_ff, nxt_ctl;
  ocsc_lim_t lim_ff, nxt_lim;
  logic [HL-1:0] hist_ff, nxt_hist;
  logic reqThis_ff, nxt_reqThis;
  logic answered_ff, nxt_answered;
  logic [3:0] missCnt_ff, nxt_missCnt;
  logic [4:0] restartCnt_ff, nxt_restartCnt;
  logic [31:0] qualCnt_ff, nxt_qualCnt;
  logic ccToggle_ff, nxt_ccToggle;
  logic reqPend_ff, nxt_reqPend;
  logic fwdPrev_ff, nxt_fwdPrev;
  logic [10:0] onCnt_ff, nxt_onCnt;
  logic cycleRequest_ff, nxt_cycleRequest;
  logic gate_ff, nxt_gate;
  logic switch_ff, nxt_switch;
  logic surgeBlock_ff, nxt_surgeBlock;
  logic [31:0] rdData_ff, nxt_rdData;
  logic inCtl_ff, nxt_inCtl;
  logic tick, want, req, fwdFall, lineOk;
  logic [3:0] ones;
  ocsc_lim_t target;

  // Next-state logic for the whole control path
  always_comb begin
    nxt_ctrl = ctrl_ff;
    nxt_cycCnt = cycCnt_ff + 11'h001;
    nxt_period = period_ff;
    nxt_jitUp = jitUp_ff;
    nxt_jitDiv = jitDiv_ff;
    nxt_ctl = ctl_ff;
    nxt_lim = lim_ff;
    nxt_hist = hist_ff;
    nxt_reqThis = reqThis_ff;
    nxt_answered = answered_ff;
    nxt_missCnt = missCnt_ff;
    nxt_restartCnt = restartCnt_ff;
    nxt_qualCnt = qualCnt_ff;
    nxt_ccToggle = ccToggle_ff;
    nxt_reqPend = 1'b0;
    nxt_fwdPrev = fwdS;
    nxt_onCnt = onCnt_ff;
    nxt_cycleRequest = reqPend_ff;
    nxt_gate = gate_ff;
    nxt_switch = switch_ff;
    nxt_surgeBlock = surgeS; // RULE3
    nxt_rdData = 32'h0000_0000;
    fwdFall = fwdPrev_ff && !fwdS;
    lineOk = brownInS && !overVoltS; // RULE13
    tick = (cycCnt_ff >= period_ff - 11'h001); // RULE6
    want = 1'b0;
    req = 1'b0;
    ones = onesCount(hist_ff);
    target = LIM_LOWEST;

    // Register writes and reads
    if (regWrite && regAddr == ADDR_W'(`OCSC_REG_CTRL)) begin
      nxt_ctrl = regWrData[1:0];
    end
    if (regRead && regAddr == ADDR_W'(`OCSC_REG_CTRL)) begin
      nxt_rdData = {30'h0, ctrl_ff};
    end else if (regRead && regAddr == ADDR_W'(`OCSC_REG_STATUS)) begin
      nxt_rdData = {22'h0, missCnt_ff, gate_ff, surgeBlock_ff,
                    lim_ff, ctl_ff};
    end

    // Answer tracking: a forward fall marks a primary cycle
    if (fwdFall) begin
      nxt_answered = 1'b1;
      if (ctl_ff == CTL_CONTROL && !reqThis_ff) begin
        nxt_ctl = CTL_HANDSHAKE; // RULE14
      end
    end

    // Rectifier gate: on after a requested fall, off on comparator
    if (fwdFall && reqThis_ff && !surgeS && !surgeBlock_ff) begin
      nxt_gate = 1'b1; // RULE2
    end
    if (rectOffS) begin
      nxt_gate = 1'b0; // RULE10
    end
    if (surgeS || surgeBlock_ff) begin
      nxt_gate = 1'b0; // RULE3
    end

    // Primary switch on-time: ends on limit or max duty
    if (switch_ff) begin
      nxt_onCnt = onCnt_ff + 11'h001;
      if (limTripS || onCnt_ff >= MAXDUTY - 11'h001) begin
        nxt_switch = 1'b0; // RULE4
      end
    end

    // Output-low qualification, also ends current regulation
    if (outLowS && ctl_ff == CTL_CONTROL) begin
      nxt_qualCnt = qualCnt_ff + 32'h1;
      if (qualCnt_ff >= 32'(QUAL_CYCLES) - 32'h1) begin
        nxt_ctl = CTL_RESTART; // RULE1 RULE12
        nxt_restartCnt = 5'h00;
      end
    end else begin
      nxt_qualCnt = 32'h0;
    end

    // Cycle start
    if (tick) begin
      nxt_cycCnt = 11'h000;
      nxt_jitDiv = (jitDiv_ff >= JIT_EVERY - 3'h1) ? 3'h0
                                                   : jitDiv_ff + 3'h1;
      if (jitDiv_ff == 3'h0) begin
        if (jitUp_ff) begin
          nxt_period = period_ff + JIT_STEP; // RULE15
          nxt_jitUp = (period_ff + JIT_STEP < PER_MAX);
        end else begin
          nxt_period = period_ff - JIT_STEP; // RULE15
          nxt_jitUp = (period_ff - JIT_STEP <= PER_MIN);
        end
      end

      // Missed answers to the previous request
      if (reqThis_ff && !(answered_ff || fwdFall) && ctl_ff != CTL_OFF) begin
        nxt_missCnt = missCnt_ff + 4'h1;
        if (missCnt_ff >= MISS_LIMIT - 4'h1) begin
          nxt_ctl = CTL_HANDSHAKE; // RULE14
          nxt_missCnt = 4'h0;
        end
      end else if (reqThis_ff) begin
        nxt_missCnt = 4'h0;
        if (ctl_ff == CTL_HANDSHAKE) begin
          nxt_ctl = CTL_CONTROL;
        end
      end
      nxt_answered = 1'b0;

      // Sample feedback to decide this cycle
      unique case (ctl_ff)
        CTL_OFF: begin
          if (lineOk && ctrl_ff[`OCSC_CTRL_EN_BIT]) begin
            nxt_ctl = CTL_HANDSHAKE;
          end
        end
        CTL_HANDSHAKE: want = 1'b1;
        CTL_CONTROL: want = fbLowS; // RULE6
        CTL_RESTART: begin
          nxt_restartCnt = restartCnt_ff + 5'h01;
          if (restartCnt_ff >= RESTART_CYC - 5'h01) begin
            nxt_ctl = CTL_HANDSHAKE;
          end
        end
      endcase
      if (want && curSenseS && ctrl_ff[`OCSC_CTRL_CC_BIT]) begin
        nxt_ccToggle = !ccToggle_ff;
        want = ccToggle_ff; // RULE11
      end
      req = want && lineOk && ctrl_ff[`OCSC_CTRL_EN_BIT]; // RULE13
      nxt_reqThis = req;
      nxt_hist = {hist_ff[HL-2:0], req};
      if (req) begin
        nxt_gate = 1'b0; // RULE9
        nxt_reqPend = 1'b1;
        nxt_switch = 1'b1; // RULE4
        nxt_onCnt = 11'h000;
      end

      // Limit level: step one level toward the load estimate
      if (ones >= 4'(`OCSC_LVL_TOP)) begin
        target = LIM_HIGHEST; // RULE7
      end else if (ones >= 4'(`OCSC_LVL_MID)) begin
        target = LIM_HIGH;
      end else if (ones >= 4'(`OCSC_LVL_LOW)) begin
        target = LIM_LOW;
      end
      if (target > lim_ff) begin
        nxt_lim = ocsc_lim_t'(lim_ff + 2'h1); // RULE8
      end else if (target < lim_ff) begin
        nxt_lim = ocsc_lim_t'(lim_ff - 2'h1); // RULE8
      end
    end

    // A started cycle runs on; line loss or a cleared enable bit stops new ones
    if (!lineOk || !ctrl_ff[`OCSC_CTRL_EN_BIT]) begin
      nxt_ctl = CTL_OFF; // RULE13 RULE5
    end
    nxt_inCtl = (nxt_ctl == CTL_CONTROL);
  end

  // Register the control path
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ctrl_ff <= `OCSC_CTRL_RESET;
      cycCnt_ff <= 11'h000;
      period_ff <= PER_NOM;
      jitUp_ff <= 1'b1;
      jitDiv_ff <= 3'h0;
      ctl_ff <= CTL_OFF;
      lim_ff <= LIM_HIGHEST;
      hist_ff <= '0;
      reqThis_ff <= 1'b0;
      answered_ff <= 1'b0;
      missCnt_ff <= 4'h0;
      restartCnt_ff <= 5'h00;
      qualCnt_ff <= 32'h0;
      ccToggle_ff <= 1'b0;
      reqPend_ff <= 1'b0;
      fwdPrev_ff <= 1'b0;
      onCnt_ff <= 11'h000;
      cycleRequest_ff <= 1'b0;
      gate_ff <= 1'b0;
      switch_ff <= 1'b0;
      surgeBlock_ff <= 1'b0;
      rdData_ff <= 32'h0000_0000;
      inCtl_ff <= 1'b0;
    end else begin
      ctrl_ff <= nxt_ctrl;
      cycCnt_ff <= nxt_cycCnt;
      period_ff <= nxt_period;
      jitUp_ff <= nxt_jitUp;
      jitDiv_ff <= nxt_jitDiv;
      ctl_ff <= nxt_ctl;
      lim_ff <= nxt_lim;
      hist_ff <= nxt_hist;
      reqThis_ff <= nxt_reqThis;
      answered_ff <= nxt_answered;
      missCnt_ff <= nxt_missCnt;
      restartCnt_ff <= nxt_restartCnt;
      qualCnt_ff <= nxt_qualCnt;
      ccToggle_ff <= nxt_ccToggle;
      reqPend_ff <= nxt_reqPend;
      fwdPrev_ff <= nxt_fwdPrev;
      onCnt_ff <= nxt_onCnt;
      cycleRequest_ff <= nxt_cycleRequest;
      gate_ff <= nxt_gate;
      switch_ff <= nxt_switch;
      surgeBlock_ff <= nxt_surgeBlock;
      rdData_ff <= nxt_rdData;
      inCtl_ff <= nxt_inCtl;
    end
  end

  // Outputs straight from flip-flops
  assign regRdData = rdData_ff;
  assign cycleRequest = cycleRequest_ff;
  assign rectifierGateDrive = gate_ff;
  assign powerSwitchOn = switch_ff;
  assign currentLimitLevel = lim_ff;
  assign secondaryInControl = inCtl_ff;

endmodule // ocsc_onoff_cycle_skip_control
`default_nettype wire

// *** rtl/ocsc_params.svh ***
`ifndef OCSC_PARAMS_SVH
`define OCSC_PARAMS_SVH
// Clock and cycle oscillator
`define OCSC_CLK_MHZ 100
`define OCSC_CYC_KHZ 100
`define OCSC_CYC_PERIOD (`OCSC_CLK_MHZ * 1000 / `OCSC_CYC_KHZ)
// Jitter: peak-to-peak and modulation rate in kHz
`define OCSC_JIT_PP_KHZ 6
`define OCSC_JIT_MOD_KHZ 1
`define OCSC_JIT_OFS (`OCSC_CYC_PERIOD * `OCSC_JIT_PP_KHZ / 2 / `OCSC_CYC_KHZ)
`define OCSC_JIT_HALF (`OCSC_CYC_KHZ / `OCSC_JIT_MOD_KHZ / 2)
`define OCSC_JIT_EVERY 5
`define OCSC_JIT_STEP (2 * `OCSC_JIT_OFS * `OCSC_JIT_EVERY / `OCSC_JIT_HALF)
// Longest on-time as a percentage of the cycle
`define OCSC_MAXDUTY_PCT 65
`define OCSC_MAXDUTY_CYC (`OCSC_CYC_PERIOD * `OCSC_MAXDUTY_PCT / 100)
// Output-low qualification time in microseconds
`define OCSC_QUAL_US 100
`define OCSC_QUAL_CYC (`OCSC_QUAL_US * `OCSC_CLK_MHZ)
// Cycle counts
`define OCSC_MISS_LIMIT 14
`define OCSC_RESTART_CYCLES 20
`define OCSC_HIST_LEN 8
`define OCSC_LVL_TOP 6
`define OCSC_LVL_MID 4
`define OCSC_LVL_LOW 2
// Register map
`define OCSC_REG_CTRL 4'h0
`define OCSC_REG_STATUS 4'h4
`define OCSC_CTRL_EN_BIT 0
`define OCSC_CTRL_CC_BIT 1
`define OCSC_CTRL_RESET 2'h3
`endif

// *** rtl/ocsc_pkg.sv ***
package ocsc_pkg;
  // Secondary control phases
  typedef enum logic [1:0] {
    CTL_OFF, CTL_HANDSHAKE, CTL_CONTROL, CTL_RESTART
  } ocsc_ctl_t;
  // Four current-limit levels, lowest first
  typedef enum logic [1:0] {
    LIM_LOWEST, LIM_LOW, LIM_HIGH, LIM_HIGHEST
  } ocsc_lim_t;
endpackage

// *** verif/ocsc_cycle_properties.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "ocsc_params.svh"
module ocsc_cycle_properties #(
  parameter int QUAL_CYCLES = 20
) (
  input wire logic clk, // Clock
  input wire logic resetn, // Reset
  input wire logic cycleRequest, // Request
  input wire logic rectifierGateDrive, // Gate
  input wire logic powerSwitchOn, // Switch
  input wire logic [1:0] currentLimitLevel, // Level
  input wire logic secondaryInControl, // In control
  input wire logic forwardSenseInput, // Forward
  input wire logic surgeCmp, // Surge
  input wire logic rectOffCmp, // Gate off flag
  input wire logic currentLimitTrip, // Trip
  input wire logic outputLowCmp // Output low
);
  localparam int MAX_ON = `OCSC_MAXDUTY_CYC + 1;
  logic [10:0] gap_ff, nxt_gap;
  logic [9:0] on_ff, nxt_on;
  logic [15:0] low_ff, nxt_low;
  // Request spacing, switch on-time and output-low run length
  always_comb begin
    nxt_gap = cycleRequest ? 11'h001 : gap_ff + {10'h000, ~&gap_ff};
    nxt_on = powerSwitchOn ? on_ff + 10'h001 : 10'h000;
    nxt_low = outputLowCmp ? low_ff + {15'h0000, ~&low_ff} : 16'h0000;
  end
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      gap_ff <= 11'h7FF;
      on_ff <= 10'h000;
      low_ff <= 16'h0000;
    end else begin
      gap_ff <= nxt_gap;
      on_ff <= nxt_on;
      low_ff <= nxt_low;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  sequence fwdFall;
    $past(forwardSenseInput, 4) && !$past(forwardSenseInput, 3);
  endsequence
  sequence reqRecent;
    gap_ff < 11'h407;
  endsequence
  chk_req_spacing: assert property (cycleRequest |-> gap_ff >= 11'h3CA)
    else $error("requests too close");
  chk_gate_cause: assert property ($rose(rectifierGateDrive) |->
    fwdFall and reqRecent) else $error("gate on without cause");
  chk_surge_block: assert property (surgeCmp [*4] |-> !rectifierGateDrive)
    else $error("gate on during surge");
  chk_gate_req: assert property (cycleRequest |-> !rectifierGateDrive)
    else $error("gate overlaps request");
  chk_rectoff_gate: assert property (rectOffCmp [*4] |-> !rectifierGateDrive)
    else $error("gate on past turn-off");
  chk_switch_start: assert property ($rose(powerSwitchOn) |=> cycleRequest)
    else $error("switch on without cycle start");
  chk_trip_off: assert property ((currentLimitTrip && powerSwitchOn) [*3]
    |=> !powerSwitchOn) else $error("switch ignores trip");
  chk_max_duty: assert property (powerSwitchOn |-> int'(on_ff) < MAX_ON)
    else $error("on-time over limit");
  chk_level_step: assert property (!$stable(currentLimitLevel) |->
    {1'b0, currentLimitLevel} == {1'b0, $past(currentLimitLevel)} + 3'h1 ||
    {1'b0, $past(currentLimitLevel)} == {1'b0, currentLimitLevel} + 3'h1)
    else $error("level jumped");
  chk_restart_qual: assert property (int'(low_ff) > QUAL_CYCLES + 5
    |-> !secondaryInControl) else $error("control kept");
endmodule // ocsc_cycle_properties
bind ocsc_onoff_cycle_skip_control ocsc_cycle_properties #(
  .QUAL_CYCLES(QUAL_CYCLES)) u_chk (.clk, .resetn, .cycleRequest,
  .rectifierGateDrive, .powerSwitchOn, .currentLimitLevel, .secondaryInControl,
  .forwardSenseInput, .surgeCmp, .rectOffCmp, .currentLimitTrip, .outputLowCmp);
`default_nettype wire

// *** verif/ocsc_primary_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module ocsc_primary_model (
  input wire logic clk, // Clock
  input wire logic resetn, // Reset
  input wire logic cycleRequest, // Request in
  input wire logic powerSwitchOn, // Switch drive
  input wire logic mute, // Ignore requests
  input wire logic spurious, // Unrequested cycle
  input wire logic [7:0] ansDelay, // Answer delay
  input wire logic [9:0] tripAfter, // Trip on-time, 0 never
  output logic forwardSenseInput, // Forward level
  output logic currentLimitTrip // Limit trip
);
  int dly;
  int low;
  int on;
  // Answer requests with a forward fall, trip the switch after on-time
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      dly <= 0;
      low <= 0;
      on <= 0;
      forwardSenseInput <= 1'b1;
      currentLimitTrip <= 1'b0;
    end else begin
      if (cycleRequest && !mute) dly <= int'(ansDelay) + 1;
      else if (spurious) dly <= 1;
      else if (dly > 0) dly <= dly - 1;
      if (dly == 1) low <= 300;
      else if (low > 0) low <= low - 1;
      forwardSenseInput <= !(dly == 1 || low > 1);
      on <= powerSwitchOn ? on + 1 : 0;
      currentLimitTrip <= tripAfter != 0 && on >= int'(tripAfter);
    end
  end
endmodule // ocsc_primary_model
`default_nettype wire

// *** verif/ocsc_onoff_cycle_skip_control_test.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "ocsc_params.svh"
module ocsc_onoff_cycle_skip_control_test;
  import ocsc_pkg::*;
  localparam int QUAL = 20;
  logic clk = 1'b0, resetn = 1'b0, regWrite = 1'b0, regRead = 1'b0;
  logic [3:0] regAddr = 4'h0;
  logic [31:0] regWrData = 32'h0, regRdData, v, seed = 32'h1728;
  logic feedbackLow = 1'b0, outputLowCmp = 1'b0, currentSenseCmp = 1'b0;
  logic surgeCmp = 1'b0, rectOffCmp = 1'b0, lineBrownIn = 1'b1;
  logic lineOverVolt = 1'b0, mute = 1'b0, spurious = 1'b0;
  logic [7:0] ansDelay = 8'h20;
  logic [9:0] tripAfter = 10'h0C8;
  logic forwardSenseInput, currentLimitTrip, cycleRequest, gPrev = 1'b0;
  logic rectifierGateDrive, powerSwitchOn, secondaryInControl;
  logic [1:0] currentLimitLevel;
  int miscompares = 0, cmp_count = 0, reqs = 0, gates = 0, maxOn = 0;
  int onRun = 0, cycles = 0;
  ocsc_onoff_cycle_skip_control #(.QUAL_CYCLES(QUAL)) u_dut (.clk, .resetn,
    .regAddr, .regWrData, .regWrite, .regRead, .regRdData, .feedbackLow,
    .outputLowCmp, .currentSenseCmp, .surgeCmp, .forwardSenseInput,
    .rectOffCmp, .lineBrownIn, .lineOverVolt, .currentLimitTrip, .cycleRequest,
    .rectifierGateDrive, .powerSwitchOn, .currentLimitLevel,
    .secondaryInControl);
  ocsc_primary_model u_primary (.clk, .resetn, .cycleRequest, .powerSwitchOn,
    .mute, .spurious, .ansDelay, .tripAfter, .forwardSenseInput,
    .currentLimitTrip);
  always #5 clk = ~clk;
  // Window counters and the hang limit
  always @(posedge clk) begin
    cycles <= cycles + 1;
    reqs <= reqs + int'(cycleRequest);
    gates <= gates + int'(rectifierGateDrive && !gPrev);
    gPrev <= rectifierGateDrive;
    onRun <= powerSwitchOn ? onRun + 1 : 0;
    if (onRun > maxOn) maxOn <= onRun;
    if (cycles == 95000) begin
      miscompares++;
      complete_run();
    end
  end
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction
  function automatic logic [31:0] span(input int n, input int lo, input int hi);
    return {31'h0, n >= lo && n <= hi};
  endfunction
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    regWrite <= 1'b1;
    regAddr <= a;
    regWrData <= d;
    @(posedge clk);
    regWrite <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a);
    @(posedge clk);
    regRead <= 1'b1;
    regAddr <= a;
    @(posedge clk);
    regRead <= 1'b0;
    #1 v = regRdData;
  endtask
  task automatic run(input int periods);
    #1;
    reqs = 0;
    gates = 0;
    maxOn = 0;
    repeat (periods * 1000) @(posedge clk);
    #1;
  endtask
  task automatic phase(input ocsc_ctl_t p);
    rd(4'h4);
    check({30'h0, v[1:0]}, {30'h0, p});
  endtask
  task automatic complete_run;
    if (miscompares == 0 && cmp_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // Main sequence
  initial begin
    repeat (4) @(posedge clk);
    check({30'h0, currentLimitLevel}, 32'h3);
    resetn <= 1'b1;
    rd(4'h0);
    check(v, 32'h3);
    wr(4'h8, 32'hFFFF_FFFF);
    wr(4'h0, 32'hFFFF_FFFF);
    rd(4'h8);
    check(v, 32'h0);
    rd(4'h0);
    check(v, 32'h3);
    run(12);
    check({30'h0, currentLimitLevel}, 32'h0);
    phase(CTL_CONTROL);
    run(2);
    check(32'(reqs), 32'h0);
    spurious <= 1'b1;
    @(posedge clk);
    spurious <= 1'b0;
    repeat (50) @(posedge clk);
    phase(CTL_HANDSHAKE);
    feedbackLow <= 1'b1;
    run(1);
    run(8);
    check(span(reqs, 7, 9), 32'h1);
    check(span(gates, 6, 9), 32'h1);
    check(span(maxOn, 199, 206), 32'h1);
    check({30'h0, currentLimitLevel}, 32'h3);
    tripAfter <= 10'h000;
    run(3);
    check(span(maxOn, `OCSC_MAXDUTY_CYC - 2, `OCSC_MAXDUTY_CYC), 32'h1);
    tripAfter <= 10'h0C8;
    currentSenseCmp <= 1'b1;
    run(1);
    run(6);
    check(span(reqs, 2, 4), 32'h1);
    currentSenseCmp <= 1'b0;
    for (int i = 0; i < 3; i++) begin
      if (i == 0) wr(4'h0, 32'h2);
      lineOverVolt <= i == 1;
      lineBrownIn <= i != 2;
      run(2);
      check(32'(reqs), 32'h0);
      wr(4'h0, 32'h3);
      lineOverVolt <= 1'b0;
      lineBrownIn <= 1'b1;
      run(3);
    end
    mute <= 1'b1;
    run(16);
    phase(CTL_HANDSHAKE);
    mute <= 1'b0;
    run(2);
    phase(CTL_CONTROL);
    surgeCmp <= 1'b1;
    run(3);
    check(32'(gates), 32'h0);
    rd(4'h4);
    check({31'h0, v[4]}, 32'h1);
    surgeCmp <= 1'b0;
    run(2);
    check(span(gates, 1, 3), 32'h1);
    for (int i = 0; i < 8; i++) begin
      seed = xs(seed);
      feedbackLow <= seed[0];
      rectOffCmp <= seed[1];
      tripAfter <= seed[2] ? 10'h0C8 : 10'h000;
      ansDelay <= seed[15:8];
      run(1);
    end
    rectOffCmp <= 1'b0;
    feedbackLow <= 1'b1;
    run(3);
    outputLowCmp <= 1'b1;
    repeat (QUAL + 8) @(posedge clk);
    #1;
    check({31'h0, secondaryInControl}, 32'h0);
    phase(CTL_RESTART);
    complete_run();
  end
endmodule // ocsc_onoff_cycle_skip_control_test
`default_nettype wire
